// file: verilog/video_timing_host.sv
// Functional notes
// - default timing is 1280x800 at 60 Hz: 1408 clocks/line, 816 lines/frame.
// - frame rate at least 50 Hz, typically 60 Hz.
// - link pixel clock between 50 and 80 MHz, typically 68.9 MHz.
// - frame lasts 803 to 1023 line periods, typically 816.
// - exactly 800 active lines in every frame.
// - vertical blanking lasts 3 to 223 lines, typically 16.
// - line lasts 1303 to 2047 pixel clocks, typically 1408.
// - each active line carries 1280 valid clocks; qualifier alone delimits lines.
// - qualifier low 23 to 767 clocks per line, typically 128.
// - all driven outputs low while panel supply is off; pixel_ready_o still follows FIFO space.
// - qualifier and syncs change only in step with the link pixel clock.
// - lane mapping: R0-5,G0 / G1-5,B0-1 / B2-5,syncs,qualifier.
`timescale 1ns/1ps
module video_timing_host #(
  parameter int HALF_DIV    = video_timing_pkg::LINK_HALF_DIV,
  parameter int FIFO_DEPTH  = video_timing_pkg::FIFO_DEPTH,
  parameter int H_ACTIVE    = video_timing_pkg::H_ACTIVE,
  parameter int V_ACTIVE    = video_timing_pkg::V_ACTIVE
) (
  // clock and reset
  input  wire logic                                   mclk_i,
  input  wire logic                                   nrst_i,
  // panel supply state, from outside this clock domain
  input  wire logic                                   panel_power_on_i,
  // programmable totals, same clock domain
  input  wire logic [video_timing_pkg::H_W-1:0]       line_period_clocks_i,
  input  wire logic [video_timing_pkg::V_W-1:0]       frame_period_lines_i,
  // pixel source stream
  input  wire logic                                   pixel_valid_i,
  output logic                                        pixel_ready_o,
  input  wire video_timing_pkg::pixel_type            pixel_data_i,
  // link to the panel transmitter
  output logic                                        link_pixel_clock_o,
  output logic [video_timing_pkg::LANE_W-1:0]         video_lane_zero_o,
  output logic [video_timing_pkg::LANE_W-1:0]         video_lane_one_o,
  output logic [video_timing_pkg::LANE_W-1:0]         video_lane_two_o,
  // status
  output logic                                        underrun_o
);
  localparam int H_W = video_timing_pkg::H_W;
  localparam int V_W = video_timing_pkg::V_W;
  localparam int DW  = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;

  localparam logic [H_W-1:0] H_ACT     = H_W'(H_ACTIVE);
  localparam logic [H_W-1:0] H_TOT_MIN = H_W'(video_timing_pkg::H_TOTAL_MIN);
  localparam logic [H_W-1:0] H_TOT_MAX = H_W'(video_timing_pkg::H_TOTAL_MAX);
  localparam logic [H_W-1:0] H_TOT_TYP = H_W'(video_timing_pkg::H_TOTAL_TYP);
  localparam logic [H_W-1:0] H_SYNC_W  = H_W'(video_timing_pkg::LINE_SYNC_CLKS);
  localparam logic [V_W-1:0] V_ACT     = V_W'(V_ACTIVE);
  localparam logic [V_W-1:0] V_TOT_MIN = V_W'(video_timing_pkg::V_TOTAL_MIN);
  localparam logic [V_W-1:0] V_TOT_MAX = V_W'(video_timing_pkg::V_TOTAL_MAX);
  localparam logic [V_W-1:0] V_TOT_TYP = V_W'(video_timing_pkg::V_TOTAL_TYP);
  localparam logic [V_W-1:0] V_SYNC_W  = V_W'(video_timing_pkg::FRAME_SYNC_LINES);
  localparam logic [DW-1:0]  DIV_LAST  = DW'(HALF_DIV - 1);

  // ****************************************************************
  // power state synchroniser
  // ****************************************************************
  logic power_meta_r;
  logic power_r;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      power_meta_r <= 1'b0;
      power_r      <= 1'b0;
    end else begin
      power_meta_r <= panel_power_on_i;
      power_r      <= power_meta_r;
    end
  end

  // ****************************************************************
  // link clock divider
  // ****************************************************************
  logic [DW-1:0] div_cnt_r;
  logic          link_clk_r;
  wire           div_last = (div_cnt_r == DIV_LAST);
  // data changes with the falling link edge so the panel samples mid-bit
  wire           pix_en   = power_r && div_last && link_clk_r;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt_r  <= '0;
      link_clk_r <= 1'b0;
    end else if (!power_r) begin
      div_cnt_r  <= '0;
      link_clk_r <= 1'b0;
    end else begin
      div_cnt_r  <= div_last ? '0 : div_cnt_r + 1'b1;
      link_clk_r <= div_last ? !link_clk_r : link_clk_r;
    end
  end

  // ****************************************************************
  // totals, clamped to the legal window and taken at frame start
  // ****************************************************************
  wire [H_W-1:0] line_req  = (line_period_clocks_i == '0) ? H_TOT_TYP : line_period_clocks_i;
  wire [V_W-1:0] frame_req = (frame_period_lines_i == '0) ? V_TOT_TYP : frame_period_lines_i;
  wire [H_W-1:0] line_clamp  = (line_req < H_TOT_MIN) ? H_TOT_MIN :
                               (line_req > H_TOT_MAX) ? H_TOT_MAX : line_req;
  wire [V_W-1:0] frame_clamp = (frame_req < V_TOT_MIN) ? V_TOT_MIN :
                               (frame_req > V_TOT_MAX) ? V_TOT_MAX : frame_req;

  logic [H_W-1:0] line_total_r;
  logic [V_W-1:0] frame_total_r;
  logic [H_W-1:0] h_cnt_r;
  logic [V_W-1:0] v_cnt_r;

  wire h_last  = (h_cnt_r == line_total_r - 1'b1);
  wire v_last  = (v_cnt_r == frame_total_r - 1'b1);
  wire frame_wrap = h_last && v_last;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_total_r  <= H_TOT_TYP;
      frame_total_r <= V_TOT_TYP;
    end else if (!power_r || (pix_en && frame_wrap)) begin
      // totals move only between frames or while power is off, so no line is cut short
      line_total_r  <= line_clamp;
      frame_total_r <= frame_clamp;
    end
  end

  // ****************************************************************
  // pixel and line counters
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      h_cnt_r <= '0;
      v_cnt_r <= '0;
    end else if (!power_r) begin
      h_cnt_r <= '0;
      v_cnt_r <= '0;
    end else if (pix_en) begin
      h_cnt_r <= h_last ? '0 : h_cnt_r + 1'b1;
      if (h_last) begin
        v_cnt_r <= v_last ? '0 : v_cnt_r + 1'b1;
      end
    end
  end

  // ****************************************************************
  // qualifier, syncs and data fetch
  // ****************************************************************
  wire h_active = (h_cnt_r < H_ACT);
  wire v_active = (v_cnt_r < V_ACT);
  wire active   = h_active && v_active;

  video_timing_pkg::ctrl_type  ctrl_nxt;
  video_timing_pkg::pixel_type fifo_data;
  video_timing_pkg::pixel_type pixel_nxt;
  video_timing_pkg::lanes_type lanes_nxt;
  logic                        fifo_valid;

  wire line_sync_w  = (h_cnt_r >= H_ACT) && (h_cnt_r < H_ACT + H_SYNC_W);
  wire frame_sync_w = (v_cnt_r >= V_ACT) && (v_cnt_r < V_ACT + V_SYNC_W);

  assign ctrl_nxt = {active, frame_sync_w, line_sync_w};

  // a missing pixel goes out black rather than stalling the raster
  wire fifo_pop  = pix_en && active;
  wire underflow = fifo_pop && !fifo_valid;
  assign pixel_nxt = (active && fifo_valid) ? fifo_data : '0;

  pixel_fifo #(
    .WIDTH (video_timing_pkg::PIX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i     (mclk_i),
    .nrst_i     (nrst_i),
    .wr_valid_i (pixel_valid_i),
    .wr_ready_o (pixel_ready_o),
    .wr_data_i  (pixel_data_i),
    .rd_valid_o (fifo_valid),
    .rd_ready_i (fifo_pop),
    .rd_data_o  (fifo_data)
  );

  lane_packer u_pack (
    .pixel_i (pixel_nxt),
    .ctrl_i  (ctrl_nxt),
    .lanes_o (lanes_nxt)
  );

  // ****************************************************************
  // registered link outputs
  // ****************************************************************
  logic [video_timing_pkg::LANE_W-1:0] lane0_r;
  logic [video_timing_pkg::LANE_W-1:0] lane1_r;
  logic [video_timing_pkg::LANE_W-1:0] lane2_r;
  logic                                underrun_r;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lane0_r <= '0;
      lane1_r <= '0;
      lane2_r <= '0;
    end else if (!power_r) begin
      lane0_r <= '0;
      lane1_r <= '0;
      lane2_r <= '0;
    end else if (pix_en) begin
      lane0_r <= lanes_nxt.lane_zero;
      lane1_r <= lanes_nxt.lane_one;
      lane2_r <= lanes_nxt.lane_two;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      underrun_r <= 1'b0;
    end else begin
      underrun_r <= underflow;
    end
  end

  // frame rate follows from the divider setting and the totals
  assign link_pixel_clock_o = link_clk_r;
  assign video_lane_zero_o  = lane0_r;
  assign video_lane_one_o   = lane1_r;
  assign video_lane_two_o   = lane2_r;
  assign underrun_o         = underrun_r;
endmodule

// file: verilog/video_timing_pkg.sv
package video_timing_pkg;

  // ****************************************************************
  // horizontal timing, in link pixel clocks
  // ****************************************************************
  localparam int H_W             = 11;
  localparam int H_ACTIVE        = 1280;
  localparam int H_TOTAL_MIN     = 1303;
  localparam int H_TOTAL_TYP     = 1408;
  localparam int H_TOTAL_MAX     = 2047;
  localparam int H_BLANK_MIN     = 23;
  localparam int H_BLANK_TYP     = 128;
  localparam int H_BLANK_MAX     = 767;
  localparam int LINE_SYNC_CLKS  = 32;

  // ****************************************************************
  // vertical timing, in line periods
  // ****************************************************************
  localparam int V_W             = 10;
  localparam int V_ACTIVE        = 800;
  localparam int V_TOTAL_MIN     = 803;
  localparam int V_TOTAL_TYP     = 816;
  localparam int V_TOTAL_MAX     = 1023;
  localparam int V_BLANK_MIN     = 3;
  localparam int V_BLANK_TYP     = 16;
  localparam int V_BLANK_MAX     = 223;
  localparam int FRAME_SYNC_LINES = 3;

  // ****************************************************************
  // rates
  // ****************************************************************
  localparam int MCLK_HZ           = 10000000;
  localparam int PIX_CLK_MIN_KHZ   = 50000;
  localparam int PIX_CLK_TYP_KHZ   = 68900;
  localparam int PIX_CLK_MAX_KHZ   = 80000;
  localparam int FRAME_RATE_MIN_HZ = 50;
  localparam int FRAME_RATE_TYP_HZ = 60;
  localparam int LINK_HALF_DIV     = 1;

  // ****************************************************************
  // data layout
  // ****************************************************************
  localparam int COLOR_W = 6;
  localparam int LANE_W  = 7;
  localparam int PIX_W   = 3 * COLOR_W;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic [COLOR_W-1:0] red;
    logic [COLOR_W-1:0] green;
    logic [COLOR_W-1:0] blue;
  } pixel_type;

  typedef struct packed {
    logic qualifier;
    logic frame_sync;
    logic line_sync;
  } ctrl_type;

  typedef struct packed {
    logic [LANE_W-1:0] lane_two;
    logic [LANE_W-1:0] lane_one;
    logic [LANE_W-1:0] lane_zero;
  } lanes_type;

endpackage

// file: verilog/pixel_fifo.sv
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  // fill side
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // drain side
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i,
  output logic [WIDTH-1:0]      rd_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             ready_r;
  wire              empty     = (wr_ptr_r == rd_ptr_r);
  wire              push      = wr_valid_i && ready_r;
  wire              pop       = rd_ready_i && !empty;
  wire [AW:0]       wr_nxt    = wr_ptr_r + {{AW{1'b0}}, push};
  wire [AW:0]       rd_nxt    = rd_ptr_r + {{AW{1'b0}}, pop};
  wire              wrap_diff = (wr_nxt[AW] != rd_nxt[AW]);
  wire              idx_same  = (wr_nxt[AW-1:0] == rd_nxt[AW-1:0]);
  // ready from a flop so the fill side never sees a combinational path
  wire              full_nxt  = wrap_diff && idx_same;

  assign wr_ready_o = ready_r;
  assign rd_valid_o = !empty;
  assign rd_data_o  = mem[rd_ptr_r[AW-1:0]];

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= wr_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      ready_r  <= 1'b1;
    end else begin
      wr_ptr_r <= wr_nxt;
      rd_ptr_r <= rd_nxt;
      ready_r  <= !full_nxt;
    end
  end
endmodule

// file: verilog/lane_packer.sv
`timescale 1ns/1ps
module lane_packer (
  // pixel and control in
  input  wire video_timing_pkg::pixel_type pixel_i,
  input  wire video_timing_pkg::ctrl_type  ctrl_i,
  // lanes out
  output video_timing_pkg::lanes_type      lanes_o
);
  // colour and control bits spread over the three lanes
  wire [video_timing_pkg::LANE_W-1:0] zero_w = {pixel_i.green[0], pixel_i.red};
  wire [video_timing_pkg::LANE_W-1:0] one_w  = {pixel_i.blue[1:0], pixel_i.green[5:1]};
  wire [video_timing_pkg::LANE_W-1:0] two_w  = {ctrl_i.qualifier, ctrl_i.frame_sync,
                                                ctrl_i.line_sync, pixel_i.blue[5:2]};

  assign lanes_o = {two_w, one_w, zero_w};
endmodule

// file: bench/video_timing_host_properties.sv
`timescale 1ns/1ps
module host_timing_checker #(
  parameter int HALF_DIV = 1,
  parameter int H_ACTIVE = 1280
) (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  // controls
  input wire logic        panel_power_on_i,
  input wire logic [10:0] line_period_clocks_i,
  // link and status
  input wire logic        link_pixel_clock_o,
  input wire logic [6:0]  video_lane_zero_o,
  input wire logic [6:0]  video_lane_one_o,
  input wire logic [6:0]  video_lane_two_o,
  input wire logic        underrun_o
);
  logic [3:0]  pwr_r;
  logic [15:0] hold_r, q_r, b_r, ls_r;
  logic        seen_r;
  wire         ok = pwr_r == 4'hF;
  wire         q = video_lane_two_o[6];
  wire         ls = video_lane_two_o[4];
  wire [20:0]  lanes = {video_lane_two_o, video_lane_one_o, video_lane_zero_o};
  wire [10:0]  req = line_period_clocks_i;
  // clamped line total in mclk cycles
  wire [15:0]  tot = 16'(2 * HALF_DIV) * ((req == 11'h000) ? 16'h0580 :
                     (req < 11'h517) ? 16'h0517 : {5'h00, req});
  wire [15:0]  act = 16'(2 * HALF_DIV * H_ACTIVE);
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {pwr_r, hold_r, q_r, b_r, ls_r, seen_r} <= '0;
    end else begin
      pwr_r  <= panel_power_on_i ? pwr_r + {3'h0, !ok} : 4'h0;
      hold_r <= $changed(link_pixel_clock_o) ? 16'h0000 : hold_r + 16'h0001;
      q_r    <= q ? q_r + 16'h0001 : 16'h0000;
      b_r    <= (q || !ok) ? 16'h0000 : b_r + 16'h0001;
      ls_r   <= $rose(ls) ? 16'h0001 : ls_r + 16'h0001;
      seen_r <= ok && (seen_r || $rose(ls));
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  chk_power_off_quiet:
    assert property (!panel_power_on_i [*4] |-> !link_pixel_clock_o && lanes == 21'h000000)
    else $error("link active while panel off");
  chk_lanes_on_fall:
    assert property (ok && $changed(lanes) |-> $fell(link_pixel_clock_o))
    else $error("lanes moved off the falling link edge");
  chk_link_running:
    assert property (ok |-> hold_r < 16'(HALF_DIV)) else $error("link clock stalled");
  chk_active_width:
    assert property (ok && $fell(q) |-> q_r == act) else $error("active run wrong");
  chk_line_period:
    assert property (seen_r && $rose(ls) |-> ls_r == tot) else $error("line period wrong");
  chk_blank_width:
    assert property (ok && $rose(q) && b_r < tot |-> b_r == tot - act)
    else $error("line blanking wrong");
  chk_qual_alone:
    assert property (q |-> video_lane_two_o[5:4] == 2'h0) else $error("qualifier with sync");
  chk_underrun_pulse:
    assert property (underrun_o |=> !underrun_o) else $error("underrun not a pulse");
endmodule
bind video_timing_host host_timing_checker #(.HALF_DIV(HALF_DIV), .H_ACTIVE(H_ACTIVE)) i_chk (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .panel_power_on_i(panel_power_on_i),
  .line_period_clocks_i(line_period_clocks_i), .link_pixel_clock_o(link_pixel_clock_o),
  .video_lane_zero_o(video_lane_zero_o), .video_lane_one_o(video_lane_one_o),
  .video_lane_two_o(video_lane_two_o), .underrun_o(underrun_o));

// file: bench/panel_model.sv
`timescale 1ns/1ps
module panel_model (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  // link from the host
  input  wire logic       link_i,
  input  wire logic [6:0] lane_zero_i,
  input  wire logic [6:0] lane_one_i,
  input  wire logic [6:0] lane_two_i,
  // measurements
  output logic [15:0]     blank_o,
  output logic [15:0]     line_o,
  output logic [15:0]     lines_o,
  output logic [15:0]     vis_o,
  output logic [15:0]     fs_len_o,
  output logic [15:0]     bad_o
);
  logic [15:0] blk_r, ln_r, fsc_r;
  logic [3:0]  idle_r;
  logic        lk_r, q_r, ls_r, fs_r, first_r;
  video_timing_pkg::pixel_type prev_r;
  wire q = lane_two_i[6];
  wire fs = lane_two_i[5];
  wire ls = lane_two_i[4];
  wire quiet = {link_i, lane_two_i, lane_one_i, lane_zero_i} == 22'h000000;
  wire video_timing_pkg::pixel_type px = {lane_zero_i[5:0], lane_one_i[4:0], lane_zero_i[6],
                                          lane_two_i[3:0], lane_one_i[6:5]};
  // a quiet link means a new power-up: counts and fs_len_o restart; bad_o, blank_o, line_o and vis_o hold
  always @(posedge mclk_i) begin
    lk_r   <= link_i;
    idle_r <= quiet ? idle_r + {3'h0, idle_r != 4'hF} : 4'h0;
    if (!nrst_i) begin
      idle_r <= 4'h0;
      bad_o  <= 16'h0000;
    end
    if (!nrst_i || idle_r == 4'h8) begin
      {lines_o, blk_r, ln_r, fsc_r, fs_len_o} <= '0;
      {q_r, ls_r, fs_r, first_r} <= 4'h1;
    end else if (link_i && !lk_r) begin
      q_r     <= q;
      ls_r    <= ls;
      fs_r    <= fs;
      first_r <= first_r && !q;
      blk_r   <= q ? 16'h0000 : blk_r + 16'h0001;
      ln_r    <= (ls && !ls_r) ? 16'h0001 : ln_r + 16'h0001;
      fsc_r   <= fs ? fsc_r + 16'h0001 : 16'h0000;
      if (q) prev_r <= px;
      if (!q && q_r) lines_o <= lines_o + 16'h0001;
      if (q && !q_r) blank_o <= blk_r;
      if (ls && !ls_r) line_o <= ln_r;
      if (fs && !fs_r) vis_o <= lines_o;
      if (!fs && fs_r) fs_len_o <= fsc_r;
      if (q && !first_r && px != prev_r + 18'h00001) bad_o <= bad_o + 16'h0001;
    end
  end
endmodule

// file: bench/video_timing_host_bench.sv
`timescale 1ns/1ps
module video_timing_host_bench;
  localparam int HA = video_timing_pkg::H_ACTIVE;
  // four active lines bring the frame sync early and keep the run short; the frame rate is not measured here
  localparam int VA = 4;
  logic                        mclk_i = 1'b0;
  logic                        nrst_i = 1'b0;
  logic                        pwr = 1'b0;
  logic                        vld = 1'b0;
  logic [10:0]                 lpc = 11'h000;
  logic [9:0]                  fpl = 10'h000;
  logic [15:0]                 n_acc = 16'h0000;
  video_timing_pkg::pixel_type data = '0;
  logic                        rdy, lclk, und;
  logic [6:0]                  l0, l1, l2;
  logic [15:0]                 m_blk, m_line, m_lines, m_vis, m_fs, m_bad;
  int                          errors = 0;
  int                          cmp_count = 0;
  int                          cyc = 0;
  always #50 mclk_i = ~mclk_i;
  video_timing_host #(.V_ACTIVE(VA)) i_dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .panel_power_on_i(pwr), .line_period_clocks_i(lpc),
    .frame_period_lines_i(fpl), .pixel_valid_i(vld), .pixel_ready_o(rdy), .pixel_data_i(data),
    .link_pixel_clock_o(lclk), .video_lane_zero_o(l0), .video_lane_one_o(l1),
    .video_lane_two_o(l2), .underrun_o(und));
  panel_model i_panel (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .link_i(lclk), .lane_zero_i(l0), .lane_one_i(l1),
    .lane_two_i(l2), .blank_o(m_blk), .line_o(m_line), .lines_o(m_lines), .vis_o(m_vis),
    .fs_len_o(m_fs), .bad_o(m_bad));
  // counting pattern lets the panel spot lost or reordered words
  always @(posedge mclk_i) begin
    if (vld && rdy) n_acc <= n_acc + 16'h0001;
    #1 data <= {2'h0, n_acc};
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 50000) begin
      errors++;
      close_out();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic close_out;
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic t_fill;
    vld = 1'b1;
    tick(12);
    check(rdy, 1'b0, "ready while full");
    check(n_acc, 16'h0008, "words taken");
    check({lclk, l2, l1, l0}, 22'h000000, "link while off");
  endtask
  task automatic t_default;
    pwr = 1'b1;
    while (m_fs === 16'h0000) tick(1);
    check(m_blk, 128, "line blanking");
    check(m_line, 1408, "line period");
    check(m_vis, VA, "active lines");
    check(m_fs, 3 * 1408, "frame sync run");
    check(m_bad, 16'h0000, "pixel order");
  endtask
  // power off mid-line, then restart with new totals
  task automatic power_cycle(input logic [10:0] req);
    pwr = 1'b0;
    tick(4);
    check({lclk, l2, l1, l0}, 22'h000000, "outputs after power off");
    lpc = req;
    fpl = ~fpl;
    tick(12);
    pwr = 1'b1;
  endtask
  task automatic t_totals;
    logic [10:0] req [2] = '{11'h064, 11'h7FF};
    int          exp [2] = '{1303, 2047};
    for (int i = 0; i < 2; i++) begin
      power_cycle(req[i]);
      while (m_lines !== 16'h0002) tick(1);
      tick(4);
      check(m_line, exp[i], "clamped line period");
      check(m_blk, exp[i] - HA, "clamped blanking");
    end
  endtask
  task automatic t_underrun;
    logic [15:0] b0;
    b0 = m_bad;
    vld = 1'b0;
    while (und !== 1'b1) tick(1);
    tick(1);
    check(und, 1'b0, "underrun pulse length");
    tick(8);
    check(m_bad > b0, 1'b1, "black pixel sent");
    check(rdy, 1'b1, "ready once drained");
  endtask
  initial begin
    tick(3);
    nrst_i = 1'b1;
    tick(1);
    check({rdy, und, lclk, l2, l1, l0}, 24'h800000, "reset state");
    t_fill();
    t_default();
    t_totals();
    t_underrun();
    close_out();
  end
endmodule
